// [inc/dctp_map.svh]
// register map, field positions, reset values and timing counts of the
// dual channel timer; assumes a 100 MHz system clock and a 12-bit APB address
`ifndef DCTP_MAP_SVH
`define DCTP_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DCTP_CTRL_OFS 12'h000
`define DCTP_STAT_OFS 12'h004
`define DCTP_PRIO_OFS 12'h008
`define DCTP_FREQ_A_OFS 12'h010
`define DCTP_PER_A_OFS 12'h014
`define DCTP_DUTY_A_OFS 12'h018
`define DCTP_CNT_A_OFS 12'h01C
`define DCTP_FREQ_B_OFS 12'h020
`define DCTP_PER_B_OFS 12'h024
`define DCTP_DUTY_B_OFS 12'h028
`define DCTP_CNT_B_OFS 12'h02C
`define DCTP_CH_SEL 12'h020

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DCTP_CTRL_MODE_LSB 2
`define DCTP_CTRL_W32_BIT 4
`define DCTP_CTRL_POL_LSB 5
`define DCTP_STAT_RUN_LSB 2
`define DCTP_PRIO_B_LSB 4
`define DCTP_PRIO_RST 3'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DCTP_CLK_HZ 32'h05F5_E100
`define DCTP_US_PER_S 32'h000F_4240
`define DCTP_CYC_PER_US (`DCTP_CLK_HZ / `DCTP_US_PER_S)
`define DCTP_TERM16 32'h0001_0000
`define DCTP_DUTY_FULL 32'h0000_2710
`define DCTP_DIV_STEPS 6'h20

`endif

// [inc/dctp_pkg.sv]
// types of the dual channel timer
// assumes dctp_map.svh for all numbers
`default_nettype none
package dctp_pkg;

   typedef enum logic [1:0] {DCTP_ONE_SHOT, DCTP_PERIODIC, DCTP_PWM, DCTP_BAD} dctp_mode_type;

   typedef enum logic {DCTP_IDLE, DCTP_DIV} dctp_div_type;

   typedef struct packed {
      logic [1:0][31:0] cnt;
      logic [1:0][31:0] load;
      logic [1:0][31:0] freq;
      logic [1:0][31:0] per;
      logic [1:0][13:0] duty;
      logic [1:0][2:0] prio;
      logic [1:0] run;
      logic [1:0] on;
      logic [1:0] flag;
      logic [1:0] pol;
      logic [1:0] pwm;
      logic [1:0] oe;
      dctp_mode_type mode;
      logic w32;
      dctp_div_type div;
      logic div_ch;
      logic [5:0] div_cnt;
      logic [31:0] div_num;
      logic [31:0] div_rem;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic [2:0] irq_prio;
   } dctp_state_type;

endpackage

`default_nettype wire

// [hdl/dctp_timer.sv]
// one timer of two 16-bit channels, joinable to one 32-bit channel,
// with single-run, repeating and pwm modes behind an APB slave
// assumes a single 100 MHz clock and an APB master on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "dctp_map.svh"

module dctp_timer
   import dctp_pkg::*;
#(
   parameter logic [1:0] TIMER_ID = 2'h0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // pwm pins
   output logic [1:0] o_pwm,
   output logic [1:0] o_pwm_oe,
   // interrupt
   output logic o_irq,
   output logic [2:0] o_irq_prio
);

   // ----------------------------------------------------------------
   // fixed pwm pins per timer
   // ----------------------------------------------------------------
   // timers 0 and 1 have a pin on half A only, 2 on half B, 3 on both
   localparam logic [1:0] PIN_MASK = (TIMER_ID == 2'h3) ? 2'b11 :
                                     (TIMER_ID == 2'h2) ? 2'b10 : 2'b01;

   dctp_state_type s_q;
   dctp_state_type s_d;
   logic [1:0][31:0] term_w;
   logic [1:0] on_w;
   logic [1:0] evt_w;
   logic [1:0] clr_w;
   logic setup_w;
   logic wr_ctrl_w;
   logic ch_w;
   logic [39:0] per_prod_w;
   logic [32:0] rem_sh_w;
   dctp_mode_type wmode_w;

   assign setup_w = i_psel && !i_penable && (s_q.div == DCTP_IDLE);
   assign wr_ctrl_w = setup_w && i_pwrite && (i_paddr == `DCTP_CTRL_OFS);
   assign ch_w = (i_paddr & `DCTP_CH_SEL) != 12'h000;
   assign wmode_w = dctp_mode_type'(i_pwdata[`DCTP_CTRL_MODE_LSB +: 2]);
   assign per_prod_w = {8'h00, i_pwdata} * {8'h00, `DCTP_CYC_PER_US};
   assign rem_sh_w = {s_q.div_rem, s_q.div_num[31]};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      evt_w = 2'b00;
      clr_w = 2'b00;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;

      // counters, one per half; mode is shared by the timer
      for (int i = 0; i < 2; i++) begin
         // the 16-bit count is clamped, so very slow rates need 32-bit width
         if (s_q.w32 && i == 0) begin
            term_w[i] = s_q.load[i];
         end else if (s_q.load[i] > `DCTP_TERM16) begin
            term_w[i] = `DCTP_TERM16;
         end else begin
            term_w[i] = s_q.load[i];
         end
         on_w[i] = (({16'h0000, s_q.cnt[i][15:0]} + 32'h0000_0001) * `DCTP_DUTY_FULL) <=
                   (term_w[i] * {18'h0_0000, s_q.duty[i]});
         if (s_q.run[i]) begin
            if (s_q.cnt[i] >= term_w[i] - 32'h0000_0001) begin
               s_d.cnt[i] = 32'h0000_0000;
               if (s_q.mode != DCTP_PWM) begin
                  evt_w[i] = 1'b1;
               end
               if (s_q.mode == DCTP_ONE_SHOT) begin
                  s_d.run[i] = 1'b0;
               end
            end else begin
               s_d.cnt[i] = s_q.cnt[i] + 32'h0000_0001;
            end
            if (s_q.mode == DCTP_PWM && s_q.on[i] && !on_w[i]) begin
               evt_w[i] = 1'b1;
            end
         end
         s_d.on[i] = s_q.run[i] && on_w[i];
         s_d.pwm[i] = (s_q.run[i] && s_q.mode == DCTP_PWM && on_w[i]) ^ s_q.pol[i];
         s_d.oe[i] = s_q.run[i] && s_q.mode == DCTP_PWM && PIN_MASK[i];
      end

      // frequency to cycle count, one quotient bit per clock
      if (s_q.div == DCTP_DIV) begin
         if (rem_sh_w >= {1'b0, s_q.freq[s_q.div_ch]}) begin
            s_d.div_rem = rem_sh_w[31:0] - s_q.freq[s_q.div_ch];
            s_d.div_num = {s_q.div_num[30:0], 1'b1};
         end else begin
            s_d.div_rem = rem_sh_w[31:0];
            s_d.div_num = {s_q.div_num[30:0], 1'b0};
         end
         s_d.div_cnt = s_q.div_cnt - 6'h01;
         if (s_q.div_cnt == 6'h01) begin
            // a rate above the clock still gives the shortest period
            s_d.load[s_q.div_ch] = (s_d.div_num == 32'h0000_0000) ? 32'h0000_0001 : s_d.div_num;
            s_d.div = DCTP_IDLE;
            s_d.pready = 1'b1;
         end
      end

      // apb access, decoded in the setup cycle
      if (setup_w) begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         if (i_pwrite) begin
            case (i_paddr)
               `DCTP_CTRL_OFS: begin
                  if (wmode_w == DCTP_BAD || (wmode_w == DCTP_PWM && i_pwdata[`DCTP_CTRL_W32_BIT])) begin
                     s_d.pslverr = 1'b1;
                  end else begin
                     s_d.mode = wmode_w;
                     s_d.w32 = i_pwdata[`DCTP_CTRL_W32_BIT];
                     s_d.pol = i_pwdata[`DCTP_CTRL_POL_LSB +: 2];
                     for (int i = 0; i < 2; i++) begin
                        // enable 0 on both halves is the deinit
                        if (!i_pwdata[i] || s_q.load[i] == 32'h0000_0000 ||
                            (i == 1 && i_pwdata[`DCTP_CTRL_W32_BIT])) begin
                           s_d.run[i] = 1'b0;
                           s_d.cnt[i] = 32'h0000_0000;
                           s_d.on[i] = 1'b0;
                        end else if (!s_q.run[i]) begin
                           s_d.run[i] = 1'b1;
                           s_d.cnt[i] = 32'h0000_0000;
                        end
                     end
                  end
               end
               `DCTP_STAT_OFS: begin
                  clr_w = i_pwdata[1:0];
               end
               `DCTP_PRIO_OFS: begin
                  if (i_pwdata[2:0] != 3'h0) begin
                     s_d.prio[0] = i_pwdata[2:0];
                  end
                  if (i_pwdata[`DCTP_PRIO_B_LSB +: 3] != 3'h0) begin
                     s_d.prio[1] = i_pwdata[`DCTP_PRIO_B_LSB +: 3];
                  end
               end
               `DCTP_FREQ_A_OFS, `DCTP_FREQ_B_OFS: begin
                  if (i_pwdata == 32'h0000_0000 || (ch_w && s_q.w32)) begin
                     s_d.pslverr = 1'b1;
                  end else begin
                     s_d.freq[ch_w] = i_pwdata;
                     s_d.per[ch_w] = 32'h0000_0000;
                     s_d.div = DCTP_DIV;
                     s_d.div_ch = ch_w;
                     s_d.div_cnt = `DCTP_DIV_STEPS;
                     s_d.div_num = `DCTP_CLK_HZ;
                     s_d.div_rem = 32'h0000_0000;
                     s_d.pready = 1'b0;
                  end
               end
               `DCTP_PER_A_OFS, `DCTP_PER_B_OFS: begin
                  if (i_pwdata == 32'h0000_0000 || (ch_w && s_q.w32)) begin
                     s_d.pslverr = 1'b1;
                  end else begin
                     s_d.per[ch_w] = i_pwdata;
                     s_d.freq[ch_w] = 32'h0000_0000;
                     s_d.load[ch_w] = (per_prod_w[39:32] != 8'h00) ? 32'hFFFF_FFFF : per_prod_w[31:0];
                  end
               end
               `DCTP_DUTY_A_OFS, `DCTP_DUTY_B_OFS: begin
                  if (i_pwdata > `DCTP_DUTY_FULL || (ch_w && s_q.w32)) begin
                     s_d.pslverr = 1'b1;
                  end else begin
                     s_d.duty[ch_w] = i_pwdata[13:0];
                  end
               end
               default: begin
                  s_d.pslverr = 1'b1;
               end
            endcase
         end else begin
            case (i_paddr)
               `DCTP_CTRL_OFS: begin
                  s_d.prdata[1:0] = s_q.run;
                  s_d.prdata[`DCTP_CTRL_MODE_LSB +: 2] = s_q.mode;
                  s_d.prdata[`DCTP_CTRL_W32_BIT] = s_q.w32;
                  s_d.prdata[`DCTP_CTRL_POL_LSB +: 2] = s_q.pol;
               end
               `DCTP_STAT_OFS: begin
                  s_d.prdata[1:0] = s_q.flag;
                  s_d.prdata[`DCTP_STAT_RUN_LSB +: 2] = s_q.run;
               end
               `DCTP_PRIO_OFS: begin
                  s_d.prdata[2:0] = s_q.prio[0];
                  s_d.prdata[`DCTP_PRIO_B_LSB +: 3] = s_q.prio[1];
               end
               `DCTP_FREQ_A_OFS, `DCTP_FREQ_B_OFS: begin
                  s_d.prdata = s_q.freq[ch_w];
               end
               `DCTP_PER_A_OFS, `DCTP_PER_B_OFS: begin
                  s_d.prdata = s_q.per[ch_w];
               end
               `DCTP_DUTY_A_OFS, `DCTP_DUTY_B_OFS: begin
                  s_d.prdata[13:0] = s_q.duty[ch_w];
               end
               `DCTP_CNT_A_OFS, `DCTP_CNT_B_OFS: begin
                  s_d.prdata = s_q.cnt[ch_w];
               end
               default: begin
                  s_d.pslverr = 1'b1;
               end
            endcase
         end
      end

      // an event in the clearing cycle survives the clear
      s_d.flag = (s_q.flag & ~clr_w) | evt_w;
      s_d.irq = |s_d.flag;
      s_d.irq_prio = 3'h0;
      for (int i = 0; i < 2; i++) begin
         if (s_d.flag[i] && s_d.prio[i] > s_d.irq_prio) begin
            s_d.irq_prio = s_d.prio[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_q <= '0;
         s_q.prio <= {2{`DCTP_PRIO_RST}};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_prdata = s_q.prdata;
   assign o_pready = s_q.pready;
   assign o_pslverr = s_q.pslverr;
   assign o_pwm = s_q.pwm;
   assign o_pwm_oe = s_q.oe;
   assign o_irq = s_q.irq;
   assign o_irq_prio = s_q.irq_prio;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   sequence deinit_wr_s;
      wr_ctrl_w && i_pwdata[1:0] == 2'b00 && wmode_w != DCTP_BAD &&
         !(wmode_w == DCTP_PWM && i_pwdata[`DCTP_CTRL_W32_BIT]);
   endsequence

   sequence all_stopped_s;
      s_q.run == 2'b00 ##1 o_pwm_oe == 2'b00;
   endsequence

   a_oneshot_stop: assert property (
      (s_q.mode == DCTP_ONE_SHOT && evt_w[0] && !wr_ctrl_w) |=> !s_q.run[0] && s_q.flag[0])
      else $error("single-run channel kept running after expiry");

   a_periodic_reload: assert property (
      (s_q.mode == DCTP_PERIODIC && s_q.run[0] && s_q.cnt[0] == term_w[0] - 32'h0000_0001 && !wr_ctrl_w)
      |=> s_q.run[0] && s_q.cnt[0] == 32'h0000_0000)
      else $error("repeating channel did not reload");

   a_pwm_pin_mode: assert property (
      o_pwm_oe[0] |-> $past(s_q.mode) == DCTP_PWM && $past(s_q.run[0]))
      else $error("pwm pin enabled outside pwm mode");

   a_pwm_pin_fixed: assert property (
      (o_pwm_oe & ~PIN_MASK) == 2'b00)
      else $error("pwm pin driven on a channel without one");

   a_no_wide_pwm: assert property (
      !(s_q.mode == DCTP_PWM && s_q.w32))
      else $error("pwm mode with 32-bit width");

   a_width_join: assert property (
      s_q.w32 |-> !s_q.run[1])
      else $error("upper half runs while joined");

   a_deinit_stop: assert property (
      deinit_wr_s |=> all_stopped_s)
      else $error("deinit left a channel running");

   a_event_flag: assert property (
      evt_w[1] |=> s_q.flag[1] && o_irq)
      else $error("channel event lost");

   a_prio_pick: assert property (
      (s_q.flag[0] && s_q.flag[1]) |-> o_irq_prio == ((s_q.prio[0] > s_q.prio[1]) ? s_q.prio[0] : s_q.prio[1]))
      else $error("wrong interrupt priority reported");

   // ----------------------------------------------------------------
   // checks on stored settings, events and pins
   // ----------------------------------------------------------------
   a_event_flag_a: assert property (
      evt_w[0] |=> s_q.flag[0] && o_irq)
      else $error("channel A event lost");

   a_duty_range: assert property (
      {18'h0_0000, s_q.duty[0]} <= `DCTP_DUTY_FULL && {18'h0_0000, s_q.duty[1]} <= `DCTP_DUTY_FULL)
      else $error("duty setting above full scale");

   a_prio_range: assert property (
      s_q.prio[0] != 3'h0 && s_q.prio[1] != 3'h0)
      else $error("channel priority left the range 1 to 7");

   a_count_clamp: assert property (
      term_w[1] <= `DCTP_TERM16 && (s_q.w32 || term_w[0] <= `DCTP_TERM16))
      else $error("16-bit channel counts past its width");

   a_pwm_idle_level: assert property (
      (s_q.mode != DCTP_PWM) |=> o_pwm == $past(s_q.pol))
      else $error("pwm output not at polarity level outside pwm mode");

   a_pwm_no_expiry: assert property (
      (s_q.mode == DCTP_PWM && s_q.on[0] == on_w[0]) |-> !evt_w[0])
      else $error("pwm channel raised an event without a duty match");

   a_pwm_duty_event: assert property (
      (s_q.mode == DCTP_PWM && s_q.run[0] && s_q.on[0] && !on_w[0]) |-> evt_w[0])
      else $error("duty match raised no event");

   a_pin_route: assert property (
      (s_q.mode == DCTP_PWM && s_q.run[0] && PIN_MASK[0]) |=> o_pwm_oe[0])
      else $error("pwm pin not routed to the timer");

endmodule

`default_nettype wire

// [bench/tb_top.sv]
// self-checking testbench of one dual channel timer: apb tasks and scenario calls
// assumes dctp_timer with TIMER_ID 0 (pwm pin on half A only) and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "dctp_map.svh"

module tb_top;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic i_clk;
   logic i_sys_rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] o_prdata;
   logic o_pready;
   logic o_pslverr;
   logic [1:0] o_pwm;
   logic [1:0] o_pwm_oe;
   logic o_irq;
   logic [2:0] o_irq_prio;
   logic [31:0] rd;
   logic er;
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int t0 = 0;

   dctp_timer #(.TIMER_ID(2'h0)) dctp_timer_inst (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pwm(o_pwm), .o_pwm_oe(o_pwm_oe),
      .o_irq(o_irq), .o_irq_prio(o_irq_prio));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // both reads of cyc happen at edges, so the nba keeps differences exact
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
   end

   // ----------------------------------------------------------------
   // compare, bus and closing tasks
   // ----------------------------------------------------------------
   task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      check_word(name, {31'h0, exp}, {31'h0, got});
   endtask

   // holds the request until pready is seen; a frequency write answers late
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (o_pready !== 1'b1 && n < 100) begin
         n++;
         @(posedge i_clk);
      end
      check_bit("pready", 1'b1, o_pready);
      rd = o_prdata;
      er = o_pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic experr);
      apb(1'b1, a, d);
      check_bit($sformatf("pslverr wr %h", a), experr, er);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check_bit("pslverr rd", 1'b0, er);
      check_word($sformatf("reg %h", a), exp, rd);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (o_irq !== 1'b1 && n < 2000) begin
         @(posedge i_clk);
         n++;
      end
      check_bit("irq", 1'b1, o_irq);
   endtask

   // one full period of 100 cycles: the count of high samples is the duty share, or its complement on a half with inverted polarity;
   // low samples of half A are counted apart so that an unknown level cannot pass
   task automatic pwm_high(input int exp_a, input int exp_b);
      int ha;
      int la;
      int hb;
      ha = 0;
      la = 0;
      hb = 0;
      repeat (100) begin
         @(posedge i_clk);
         if (o_pwm[0] === 1'b1) ha++;
         if (o_pwm[0] === 1'b0) la++;
         if (o_pwm[1] === 1'b1) hb++;
      end
      check_word("pwm high cycles", 32'(exp_a), 32'(ha));
      check_word("pwm low cycles", 32'(100 - exp_a), 32'(la));
      check_word("pwm b high cycles", 32'(exp_b), 32'(hb));
   endtask

   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      i_sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      check_bit("irq after reset", 1'b0, o_irq);
      check_word("oe after reset", 32'h0000_0000, {30'h0, o_pwm_oe});
      rdc(`DCTP_CTRL_OFS, 32'h0000_0000);
      rdc(`DCTP_STAT_OFS, 32'h0000_0000);
      rdc(`DCTP_PRIO_OFS, 32'h0000_0011);
      // refused accesses leave everything unchanged; a full-scale duty write is accepted
      wr(12'h030, 32'h0000_0001, 1'b1);
      wr(`DCTP_CNT_A_OFS, 32'h0000_0001, 1'b1);
      wr(`DCTP_CTRL_OFS, 32'h0000_000D, 1'b1);
      wr(`DCTP_CTRL_OFS, 32'h0000_0019, 1'b1);
      wr(`DCTP_PER_A_OFS, 32'h0000_0000, 1'b1);
      wr(`DCTP_FREQ_A_OFS, 32'h0000_0000, 1'b1);
      wr(`DCTP_DUTY_A_OFS, 32'h0000_2711, 1'b1);
      wr(`DCTP_DUTY_A_OFS, 32'h0000_2710, 1'b0);
      rdc(`DCTP_CTRL_OFS, 32'h0000_0000);
      // frequency and period exclude each other
      wr(`DCTP_FREQ_A_OFS, 32'h000F_4240, 1'b0);
      rdc(`DCTP_FREQ_A_OFS, 32'h000F_4240);
      rdc(`DCTP_PER_A_OFS, 32'h0000_0000);
      wr(`DCTP_PER_A_OFS, 32'h0000_0001, 1'b0);
      rdc(`DCTP_FREQ_A_OFS, 32'h0000_0000);
      rdc(`DCTP_PER_A_OFS, 32'h0000_0001);
      wr(`DCTP_PER_B_OFS, 32'h0000_0001, 1'b0);
      wr(`DCTP_PRIO_OFS, 32'h0000_0025, 1'b0);
      // single run on both halves, 100 cycles each
      wr(`DCTP_CTRL_OFS, 32'h0000_0003, 1'b0);
      t0 = cyc;
      wait_irq();
      check_bit("expiry time", 1'b1, (cyc - t0 >= 90) && (cyc - t0 <= 110));
      repeat (3) @(posedge i_clk);
      check_word("irq prio both", 32'h0000_0005, {29'h0, o_irq_prio});
      rdc(`DCTP_STAT_OFS, 32'h0000_0003);
      wr(`DCTP_STAT_OFS, 32'h0000_0001, 1'b0);
      repeat (2) @(posedge i_clk);
      check_word("irq prio b", 32'h0000_0002, {29'h0, o_irq_prio});
      wr(`DCTP_STAT_OFS, 32'h0000_0002, 1'b0);
      repeat (250) @(posedge i_clk);
      check_bit("no second expiry", 1'b0, o_irq);
      // repeating mode, 200 cycle period
      wr(`DCTP_PER_A_OFS, 32'h0000_0002, 1'b0);
      wr(`DCTP_CTRL_OFS, 32'h0000_0005, 1'b0);
      wait_irq();
      t0 = cyc;
      wr(`DCTP_STAT_OFS, 32'h0000_0001, 1'b0);
      wait_irq();
      check_word("repeat period", 32'h0000_00C8, 32'(cyc - t0));
      rdc(`DCTP_STAT_OFS, 32'h0000_0005);
      // joined halves refuse half B settings
      wr(`DCTP_CTRL_OFS, 32'h0000_0015, 1'b0);
      wr(`DCTP_PER_B_OFS, 32'h0000_0001, 1'b1);
      wr(`DCTP_DUTY_B_OFS, 32'h0000_0001, 1'b1);
      wr(`DCTP_CTRL_OFS, 32'h0000_0000, 1'b0);
      wr(`DCTP_STAT_OFS, 32'h0000_0003, 1'b0);
      rdc(`DCTP_STAT_OFS, 32'h0000_0000);
      // pwm on both halves, only half A has a pin
      wr(`DCTP_PER_A_OFS, 32'h0000_0001, 1'b0);
      wr(`DCTP_DUTY_A_OFS, 32'h0000_09C4, 1'b0);
      wr(`DCTP_DUTY_B_OFS, 32'h0000_1388, 1'b0);
      wr(`DCTP_CTRL_OFS, 32'h0000_000B, 1'b0);
      repeat (5) @(posedge i_clk);
      check_word("oe in pwm", 32'h0000_0001, {30'h0, o_pwm_oe});
      pwm_high(25, 50);
      wr(`DCTP_CTRL_OFS, 32'h0000_002B, 1'b0);
      repeat (3) @(posedge i_clk);
      pwm_high(75, 50);
      wr(`DCTP_DUTY_A_OFS, 32'h0000_1388, 1'b0);
      rdc(`DCTP_DUTY_A_OFS, 32'h0000_1388);
      repeat (100) @(posedge i_clk);
      pwm_high(50, 50);
      rdc(`DCTP_STAT_OFS, 32'h0000_000F);
      wr(`DCTP_DUTY_A_OFS, 32'h0000_0000, 1'b0);
      repeat (100) @(posedge i_clk);
      pwm_high(100, 50);
      wr(`DCTP_DUTY_A_OFS, 32'h0000_2710, 1'b0);
      repeat (100) @(posedge i_clk);
      pwm_high(0, 50);
      // deinit stops everything
      wr(`DCTP_CTRL_OFS, 32'h0000_0000, 1'b0);
      repeat (2) @(posedge i_clk);
      check_word("oe after deinit", 32'h0000_0000, {30'h0, o_pwm_oe});
      rdc(`DCTP_CTRL_OFS, 32'h0000_0000);
      // reset while pwm runs and flags are pending must clear them all
      wr(`DCTP_CTRL_OFS, 32'h0000_000B, 1'b0);
      repeat (5) @(posedge i_clk);
      check_bit("irq before mid reset", 1'b1, o_irq);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      check_word("pins after mid reset", 32'h0000_0000, {28'h0, o_pwm_oe, o_pwm});
      check_bit("irq after mid reset", 1'b0, o_irq);
      rdc(`DCTP_STAT_OFS, 32'h0000_0000);
      rdc(`DCTP_PRIO_OFS, 32'h0000_0011);
      finish_test();
   end

endmodule

`default_nettype wire
